// File: design/bswal_regs.vh
`ifndef BSWAL_REGS_VH
`define BSWAL_REGS_VH

// ----------------------------------------------------------------
// apb register map (byte addresses)
// ----------------------------------------------------------------
`define BSWAL_ADDR_W          12
`define BSWAL_OFF_CONFIG      12'h000
`define BSWAL_OFF_STATUS      12'h004

// ----------------------------------------------------------------
// configuration register fields (1 = jumper installed)
// ----------------------------------------------------------------
`define BSWAL_CFG_W           7
`define BSWAL_CFG_BANK_LSB    0
`define BSWAL_CFG_BANK_MSB    3
`define BSWAL_CFG_ROUTE_A     4
`define BSWAL_CFG_ROUTE_B     5
`define BSWAL_CFG_TEST        6
`define BSWAL_CFG_RESET       7'h3F

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define BSWAL_STS_WORD_LSB    0
`define BSWAL_STS_WORD_MSB    12
`define BSWAL_STS_SELECT      13
`define BSWAL_STS_DC_LO       14

// ----------------------------------------------------------------
// widths and pin reset levels
// ----------------------------------------------------------------
`define BSWAL_BUS_ADDR_W      18
`define BSWAL_WORD_W          13
`define BSWAL_PIN_W           20
`define BSWAL_PIN_REST        20'hFFFFF
`define BSWAL_DIRECT_W        8
`define BSWAL_PREDEC_W        6
`define BSWAL_PREDEC_IDLE     6'h3F

`endif

// File: design/bswal_core.v
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "bswal_regs.vh"

// Behaviour
// - each bank bit compared against its jumper
// - select only when all four bits match
// - factory routing makes A14 lowest compared bit
// - power-fail line feeds the select comparator
// - test jumper forces read-only cycles
// - thirteen-bit register captures address bits 13..1 in factory routing
// - lowest register bit loads from routed A01, or from A14 without factory routing
// - all bits load on address clock rise
// - word register has no set or clear
// - eight bits go straight to decoders
// - A06 and A12/A13 make six predecode lows
// - A12/A13 decoded to four exclusive lows
// - predecode feeds switch decoders only
// - A03 and A09 gated by driver strobe
// - switch strobe from phase pulse and mode
// - driver strobe from crossed phase and mode
// - bus lines are negative logic
module bswal_core (
  input  wire                           clk,
  input  wire                           reset_n,
  // apb slave
  input  wire                           psel,
  input  wire                           penable,
  input  wire                           pwrite,
  input  wire [`BSWAL_ADDR_W-1:0]       paddr,
  input  wire [31:0]                    pwdata,
  output reg  [31:0]                    prdata,
  output reg                            pready,
  output reg                            pslverr,
  // bus pins, low = asserted
  input  wire [`BSWAL_BUS_ADDR_W-1:0]   bus_addr_l,
  input  wire                           bus_dc_lo_l,
  input  wire                           bus_write_req_l,
  // control timing logic, same clock
  input  wire                           addr_clk,
  input  wire                           read_mode,
  input  wire                           read_phase_pulse,
  input  wire                           write_phase_pulse,
  // towards control logic
  output reg                            device_select,
  output reg                            cycle_write,
  // towards line decoders
  output reg                            switch_timing_strobe,
  output reg                            driver_timing_strobe,
  output reg  [`BSWAL_DIRECT_W-1:0]     direct_bits,
  output reg  [`BSWAL_PREDEC_W-1:0]     switch_predec_n,
  output reg  [1:0]                     driver_gated
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [`BSWAL_PIN_W-1:0] pin_vec;
  reg  [`BSWAL_PIN_W-1:0] pin_meta;
  reg  [`BSWAL_PIN_W-1:0] pin_sync;

  assign pin_vec = {bus_write_req_l, bus_dc_lo_l, bus_addr_l};

  // two flops per pin; nothing but the second flop reads the first
  genvar gp;
  generate
    for (gp = 0; gp < `BSWAL_PIN_W; gp = gp + 1) begin : g_sync
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          pin_meta[gp] <= 1'b1;
          pin_sync[gp] <= 1'b1;
        end else begin
          pin_meta[gp] <= pin_vec[gp];
          pin_sync[gp] <= pin_meta[gp];
        end
      end
    end
  endgenerate

  // low level on the wire means logical one
  wire [`BSWAL_BUS_ADDR_W-1:0] rx_addr;
  wire                         rx_dc_lo;
  wire                         rx_write;

  assign rx_addr  = ~pin_sync[`BSWAL_BUS_ADDR_W-1:0];
  assign rx_dc_lo = ~pin_sync[`BSWAL_BUS_ADDR_W];
  assign rx_write = ~pin_sync[`BSWAL_BUS_ADDR_W+1];

  // ----------------------------------------------------------------
  // configuration register (jumpers)
  // ----------------------------------------------------------------
  reg  [`BSWAL_CFG_W-1:0] cfg;
  wire [3:0]              bank_jumper;
  wire                    factory_bit_route_a;
  wire                    factory_bit_route_b;
  wire                    read_only_test_jumper;
  wire                    factory_ok;

  // installed jumpers are ones; written only by software setup
  assign bank_jumper = cfg[`BSWAL_CFG_BANK_MSB:`BSWAL_CFG_BANK_LSB];
  assign factory_bit_route_a   = cfg[`BSWAL_CFG_ROUTE_A];
  assign factory_bit_route_b   = cfg[`BSWAL_CFG_ROUTE_B];
  assign read_only_test_jumper = cfg[`BSWAL_CFG_TEST];
  assign factory_ok = factory_bit_route_a & factory_bit_route_b;

  // ----------------------------------------------------------------
  // bank comparator
  // ----------------------------------------------------------------
  wire       low_cmp_bit;
  wire [3:0] cmp_in;
  wire [3:0] cmp_expect;
  wire [3:0] cmp_match;
  wire       next_device_select;

  // factory routing picks A14 as the lowest compared bit
  assign low_cmp_bit = factory_ok ? rx_addr[14] : rx_addr[1];
  assign cmp_in      = {rx_addr[17:15], low_cmp_bit};
  // jumper in demands zero, jumper out demands one
  assign cmp_expect  = ~bank_jumper;

  genvar gc;
  generate
    for (gc = 0; gc < 4; gc = gc + 1) begin : g_cmp
      assign cmp_match[gc] = ~(cmp_in[gc] ^ cmp_expect[gc]);
    end
  endgenerate

  // power-fail blocks selection so no cycle starts on a dying bus
  assign next_device_select = (&cmp_match) & ~rx_dc_lo;

  // ----------------------------------------------------------------
  // word address register
  // ----------------------------------------------------------------
  reg                      addr_clk_d;
  wire                     addr_clk_rise;
  wire                     low_word_bit_routed;
  wire [`BSWAL_WORD_W-1:0] word_din;
  reg  [`BSWAL_WORD_W-1:0] word_reg;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_clk_d <= 1'b0;
    end else begin
      addr_clk_d <= addr_clk;
    end
  end

  assign addr_clk_rise = addr_clk & ~addr_clk_d;

  // in 8K routing the low bit comes through the bank selector
  assign low_word_bit_routed = factory_ok ? rx_addr[1] : rx_addr[14];
  assign word_din = {rx_addr[13:2], low_word_bit_routed};

  // no reset here: contents are undefined until the first load
  genvar gw;
  generate
    for (gw = 0; gw < `BSWAL_WORD_W; gw = gw + 1) begin : g_word
      always @(posedge clk) begin
        if (addr_clk_rise) begin
          word_reg[gw] <= word_din[gw];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // timing strobes
  // ----------------------------------------------------------------
  wire next_switch_strobe;
  wire next_driver_strobe;

  assign next_switch_strobe = (read_mode & read_phase_pulse) |
                              (~read_mode & write_phase_pulse);
  assign next_driver_strobe = (write_phase_pulse & read_mode) |
                              (read_phase_pulse & ~read_mode);

  // ----------------------------------------------------------------
  // predecode and gating
  // ----------------------------------------------------------------
  wire                       a03;
  wire                       a06;
  wire                       a09;
  wire                       a12;
  wire                       a13;
  wire [`BSWAL_DIRECT_W-1:0] next_direct;
  wire [`BSWAL_PREDEC_W-1:0] next_predec_n;
  wire [1:0]                 next_driver_gated;

  assign a03 = word_reg[2];
  assign a06 = word_reg[5];
  assign a09 = word_reg[8];
  assign a12 = word_reg[11];
  assign a13 = word_reg[12];

  // A01 A02 A04 A05 A07 A08 A10 A11, ungated
  assign next_direct = {word_reg[10], word_reg[9], word_reg[7],
                        word_reg[6], word_reg[4], word_reg[3],
                        word_reg[1], word_reg[0]};

  // switch decoders only; the driver path never sees these
  assign next_predec_n[0] = ~(next_switch_strobe & a06);
  assign next_predec_n[1] = ~(next_switch_strobe & ~a06);
  assign next_predec_n[2] = ~(next_switch_strobe & a12 & a13);
  assign next_predec_n[3] = ~(next_switch_strobe & ~a12 & a13);
  assign next_predec_n[4] = ~(next_switch_strobe & a12 & ~a13);
  assign next_predec_n[5] = ~(next_switch_strobe & ~a12 & ~a13);

  assign next_driver_gated = {a09 & next_driver_strobe,
                              a03 & next_driver_strobe};

  // ----------------------------------------------------------------
  // cycle direction
  // ----------------------------------------------------------------
  wire next_cycle_write;

  // with the test jumper in, a write request still runs a read cycle,
  // so the stack can be exercised without its contents being altered
  assign next_cycle_write = rx_write & ~read_only_test_jumper;

  // ----------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------
  // one cycle of latency buys clean, reset-defined decoder lines
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      device_select        <= 1'b0;
      cycle_write          <= 1'b0;
      switch_timing_strobe <= 1'b0;
      driver_timing_strobe <= 1'b0;
      direct_bits          <= {`BSWAL_DIRECT_W{1'b0}};
      switch_predec_n      <= `BSWAL_PREDEC_IDLE;
      driver_gated         <= 2'h0;
    end else begin
      device_select        <= next_device_select;
      cycle_write          <= next_cycle_write;
      switch_timing_strobe <= next_switch_strobe;
      driver_timing_strobe <= next_driver_strobe;
      direct_bits          <= next_direct;
      switch_predec_n      <= next_predec_n;
      driver_gated         <= next_driver_gated;
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  wire        apb_setup;
  wire        apb_commit;
  wire        hit_config;
  wire        hit_status;
  wire        hit_any;
  wire        write_refused;
  wire        next_pslverr;
  reg  [31:0] next_prdata;

  assign apb_setup  = psel & ~penable;
  assign apb_commit = psel & penable & pready;
  assign hit_config = (paddr == `BSWAL_OFF_CONFIG);
  assign hit_status = (paddr == `BSWAL_OFF_STATUS);

  // status is read-only, so a write there is refused like a hole
  assign hit_any       = hit_config | hit_status;
  assign write_refused = pwrite & hit_status;
  assign next_pslverr  = apb_setup & (~hit_any | write_refused);

  always @* begin
    next_prdata = 32'h00000000;
    if (hit_config) begin
      next_prdata[`BSWAL_CFG_W-1:0] = cfg;
    end else if (hit_status) begin
      next_prdata[`BSWAL_STS_WORD_MSB:`BSWAL_STS_WORD_LSB] = word_reg;
      next_prdata[`BSWAL_STS_SELECT] = device_select;
      next_prdata[`BSWAL_STS_DC_LO]  = rx_dc_lo;
    end
  end

  // answer is prepared in setup so the access phase has no wait
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= apb_setup;
      pslverr <= next_pslverr;
      if (apb_setup && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= `BSWAL_CFG_RESET;
    end else if (apb_commit && pwrite && hit_config) begin
      cfg <= pwdata[`BSWAL_CFG_W-1:0];
    end
  end

endmodule // bswal_core

// File: tb/bswal_core_properties.sv
`timescale 1ns/1ps
`include "bswal_regs.vh"
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module bswal_core_properties (
  input wire                       clk,
  input wire                       reset_n,
  input wire                       psel,
  input wire                       penable,
  input wire                       pwrite,
  input wire [`BSWAL_ADDR_W-1:0]   paddr,
  input wire                       pready,
  input wire                       pslverr,
  input wire                       bus_dc_lo_l,
  input wire                       read_mode,
  input wire                       read_phase_pulse,
  input wire                       write_phase_pulse,
  input wire                       device_select,
  input wire                       switch_timing_strobe,
  input wire                       driver_timing_strobe,
  input wire [`BSWAL_PREDEC_W-1:0] switch_predec_n,
  input wire [1:0]                 driver_gated
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // past() guard: first edge after release still sees reset-time inputs
  a_switch_strobe: assert property ($past(reset_n) |->
    switch_timing_strobe == $past(read_mode & read_phase_pulse |
    ~read_mode & write_phase_pulse)) else $error("switch strobe wrong");
  a_driver_strobe: assert property ($past(reset_n) |->
    driver_timing_strobe == $past(read_mode & write_phase_pulse |
    ~read_mode & read_phase_pulse)) else $error("driver strobe wrong");
  a_predec_idle: assert property (!switch_timing_strobe |->
    switch_predec_n == `BSWAL_PREDEC_IDLE) else $error("predecode active");
  a_predec_exclusive: assert property (switch_timing_strobe |->
    $onehot(~switch_predec_n[5:2]) && $onehot(~switch_predec_n[1:0]))
    else $error("predecode not exclusive");
  a_driver_idle: assert property (!driver_timing_strobe |->
    driver_gated == 2'b00) else $error("driver gate open");
  a_power_fail: assert property (!bus_dc_lo_l [*4] |->
    !device_select) else $error("select during power fail");
  a_status_refused: assert property (psel && penable && pwrite &&
    paddr == `BSWAL_OFF_STATUS |-> pready && pslverr)
    else $error("status write accepted");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_zero_wait: assert property (psel && !penable |=> pready)
    else $error("pready late");
  c_strobe: cover property (switch_timing_strobe && driver_timing_strobe);
  c_power: cover property (!bus_dc_lo_l ##3 !device_select);
  c_error: cover property (pready && pslverr);
endmodule // bswal_core_properties

bind bswal_core bswal_core_properties u_bswal_core_properties (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .bus_dc_lo_l(bus_dc_lo_l), .read_mode(read_mode),
  .read_phase_pulse(read_phase_pulse),
  .write_phase_pulse(write_phase_pulse), .device_select(device_select),
  .switch_timing_strobe(switch_timing_strobe),
  .driver_timing_strobe(driver_timing_strobe),
  .switch_predec_n(switch_predec_n), .driver_gated(driver_gated));

// File: tb/bswal_bus_master.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bus master: logical values in, negative-logic pins out
// ----------------------------------------------------------------
module bswal_bus_master (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [17:0] addr,
  input  wire        dc_lo,
  input  wire        wr_req,
  output reg  [17:0] bus_addr_l,
  output reg         bus_dc_lo_l,
  output reg         bus_write_req_l
);
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_addr_l      <= 18'h3FFFF;
      bus_dc_lo_l     <= 1'b1;
      bus_write_req_l <= 1'b1;
    end else begin
      bus_addr_l      <= ~addr;
      bus_dc_lo_l     <= ~dc_lo;
      bus_write_req_l <= ~wr_req;
    end
  end
endmodule // bswal_bus_master

// File: tb/bswal_core_test.sv
`timescale 1ns/1ps
`include "bswal_regs.vh"
module bswal_core_test;
  logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  logic        addr_clk = 0, read_mode = 0, rp = 0, wp = 0;
  logic [17:0] addr = 0;
  logic        dc_lo = 0, wr_req = 0, e, s, d;
  logic [5:0]  pd;
  logic [12:0] w;
  wire  [31:0] prdata;
  wire  [17:0] bus_addr_l;
  wire         pready, pslverr, bus_dc_lo_l, bus_write_req_l, sel, cw;
  wire         sw_strobe, dr_strobe;
  wire  [7:0]  direct_bits;
  wire  [5:0]  predec_n;
  wire  [1:0]  driver_gated;
  integer      errors = 0, n_checks = 0, cycles = 0, i, b;

  bswal_core u_bswal_core (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_addr_l(bus_addr_l), .bus_dc_lo_l(bus_dc_lo_l),
    .bus_write_req_l(bus_write_req_l), .addr_clk(addr_clk),
    .read_mode(read_mode), .read_phase_pulse(rp), .write_phase_pulse(wp),
    .device_select(sel), .cycle_write(cw), .switch_timing_strobe(sw_strobe),
    .driver_timing_strobe(dr_strobe), .direct_bits(direct_bits),
    .switch_predec_n(predec_n), .driver_gated(driver_gated));
  bswal_bus_master u_bswal_bus_master (.clk(clk), .reset_n(reset_n),
    .addr(addr), .dc_lo(dc_lo), .wr_req(wr_req), .bus_addr_l(bus_addr_l),
    .bus_dc_lo_l(bus_dc_lo_l), .bus_write_req_l(bus_write_req_l));

  always #2.5 clk = ~clk;

  task give_verdict;
    begin
      if (errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      give_verdict;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    begin
      n_checks = n_checks + 1;
      if (g !== x) begin
        errors = errors + 1;
        $display("wrong value at %0t: got %h want %h", $time, g, x);
      end
    end
  endtask
  // one apb transfer; holds everything until pready is seen high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
    begin
      psel    <= 1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= dat;
      penable <= 0;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      // only pready or the bench timeout may end this wait
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel    <= 0;
      penable <= 0;
      @(posedge clk);
    end
  endtask
  // synchroniser plus model flop settle within six edges
  task set_bus(input logic [17:0] a);
    begin
      addr <= a;
      repeat (6) @(posedge clk);
    end
  endtask
  task load;
    begin
      addr_clk <= 1;
      @(posedge clk);
      addr_clk <= 0;
      repeat (3) @(posedge clk);
    end
  endtask

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1;
    @(posedge clk);
    apb(0, `BSWAL_OFF_CONFIG, 0);
    chk(q, 32'h3F);
    chk(e, 0);
    apb(1, `BSWAL_OFF_STATUS, 0);
    chk(e, 1);
    apb(0, 12'h008, 0);
    chk(q, 0);
    chk(e, 1);
    for (b = 0; b < 16; b = b + 1) begin
      apb(1, `BSWAL_OFF_CONFIG, 32'h30 | (~b & 15));
      set_bus(b << 14);
      chk(sel, 1);
      set_bus((b ^ (1 << (b % 4))) << 14);
      chk(sel, 0);
    end
    apb(1, `BSWAL_OFF_CONFIG, 32'h3F);
    set_bus(0);
    chk(sel, 1);
    dc_lo <= 1;
    set_bus(0);
    chk(sel, 0);
    apb(0, `BSWAL_OFF_STATUS, 0);
    chk(q[14:13], 2'b10);
    dc_lo  <= 0;
    wr_req <= 1;
    set_bus(0);
    chk(cw, 1);
    apb(1, `BSWAL_OFF_CONFIG, 32'h7F);
    set_bus(0);
    chk(cw, 0);
    apb(1, `BSWAL_OFF_CONFIG, 32'h3F);
    for (b = 0; b < 2; b = b + 1) begin
      w = b ? 13'h1555 : 13'h0AAA;
      set_bus({4'h0, w, 1'b0});
      load;
      apb(0, `BSWAL_OFF_STATUS, 0);
      chk(q[12:0], w);
      chk(direct_bits, {w[10:9], w[7:6], w[4:3], w[1:0]});
      set_bus({4'h0, ~w, 1'b0});
      apb(0, `BSWAL_OFF_STATUS, 0);
      chk(q[12:0], w);
      for (i = 0; i < 8; i = i + 1) begin
        {read_mode, wp, rp} <= i[2:0];
        repeat (2) @(posedge clk);
        s = read_mode & rp | ~read_mode & wp;
        d = read_mode & wp | ~read_mode & rp;
        // six-bit target keeps the inversion from filling upper bits
        pd = ~({~w[11] & ~w[12], w[11] & ~w[12], ~w[11] & w[12],
          w[11] & w[12], ~w[5], w[5]} & {6{s}});
        chk(sw_strobe, s);
        chk(dr_strobe, d);
        chk(predec_n, pd);
        chk(driver_gated, {w[8], w[2]} & {2{d}});
      end
    end
    apb(1, `BSWAL_OFF_CONFIG, 32'h2F);
    set_bus(18'h04000);
    chk(sel, 1);
    load;
    apb(0, `BSWAL_OFF_STATUS, 0);
    chk(q[0], 1);
    give_verdict;
  end
endmodule // bswal_core_test
